// >>> rtl/fps_pkg.sv
// package: opcodes, timing, commands and carriers for the flash protect host
package fps_pkg;

  // =====================================================================
  // opcodes known for this command set
  // =====================================================================
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_REGION_LOCK = 8'h36;
  localparam logic [7:0] OP_REGION_UNLOCK = 8'h39;
  localparam logic [7:0] OP_LOCK_STATUS_READ = 8'h3C;
  localparam logic [7:0] OP_CHIP_LOCK = 8'h7E;
  localparam logic [7:0] OP_CHIP_UNLOCK = 8'h98;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'h30;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;

  // =====================================================================
  // security register bit positions (device side, for the user's decode)
  // =====================================================================
  localparam int SEC_BIT_OTP_LOCKDOWN = 1;
  localparam int SEC_BIT_PROG_SUSPENDED = 2;
  localparam int SEC_BIT_ERASE_SUSPENDED = 3;
  localparam int SEC_BIT_PROG_FAIL = 5;
  localparam int SEC_BIT_ERASE_FAIL = 6;
  localparam int SEC_BIT_PROTECT_MODE = 7;

  // =====================================================================
  // frame lengths and timing
  // =====================================================================
  localparam logic [5:0] BITS_BYTE = 6'h08;
  localparam logic [5:0] BITS_OP_ADDR = 6'h20;
  localparam logic [5:0] BITS_NONE = 6'h00;
  localparam int CLK_MHZ = 200;
  localparam int SUSPEND_WAIT_NS = 20000;
  localparam int RESUME_WAIT_US = 1000;
  // least times round up to whole cycles
  localparam int SUSPEND_WAIT_CYC = (SUSPEND_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int RESUME_WAIT_CYC = RESUME_WAIT_US * CLK_MHZ;
  localparam int SCK_HALF_CYC = 4;
  localparam int CS_GAP_CYC = 10;
  localparam int RESET_RECOVER_CYC = 2000;

  // =====================================================================
  // user commands and carriers
  // =====================================================================
  typedef enum logic [3:0] {
    CMD_SEC_READ = 4'h0,
    CMD_SEC_WRITE = 4'h1,
    CMD_PROT_SEL = 4'h2,
    CMD_LOCK = 4'h3,
    CMD_UNLOCK = 4'h4,
    CMD_LOCK_RD = 4'h5,
    CMD_CHIP_LOCK = 4'h6,
    CMD_CHIP_UNLOCK = 4'h7,
    CMD_SUSPEND = 4'h8,
    CMD_RESUME = 4'h9,
    CMD_NOP = 4'hA,
    CMD_RESET = 4'hB
  } fps_cmd_t;

  typedef struct packed {
    fps_cmd_t code;
    logic [23:0] addr;
  } fps_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] data;
  } fps_rsp_t;

endpackage

// >>> rtl/fps_host.sv
// module: host controller issuing protect, suspend and reset commands
`timescale 1ns/1ps
`default_nettype none

module fps_host #(
  parameter int RESUME_GAP_CYC = fps_pkg::RESUME_WAIT_CYC,
  parameter int RECOVER_CYC = fps_pkg::RESET_RECOVER_CYC,
  parameter int SCK_HALF = fps_pkg::SCK_HALF_CYC,
  parameter int GAP_CYC = fps_pkg::CS_GAP_CYC,
  parameter logic [7:0] OP_SEC_READ = 8'hA1,
  parameter logic [7:0] OP_SEC_WRITE = 8'hA2,
  parameter logic [7:0] OP_PROT_SEL = 8'hA3,
  parameter logic [7:0] OP_NOP = 8'h00
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire fps_pkg::fps_req_t req,
  output logic req_ready,
  output fps_pkg::fps_rsp_t rsp,
  output logic busy,
  output logic flash_cs_n,
  output logic flash_sck,
  output logic flash_mosi,
  input wire logic flash_miso
);

  // =====================================================================
  // constants at register width
  // =====================================================================
  localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);
  localparam logic [7:0] GAP_M1 = 8'(GAP_CYC - 1);
  localparam logic [17:0] SUSP_WAIT = 18'(fps_pkg::SUSPEND_WAIT_CYC);
  localparam logic [17:0] RES_WAIT = 18'(RESUME_GAP_CYC);
  localparam logic [17:0] RST_WAIT = 18'(RECOVER_CYC);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_LOAD = 3'b011,
    ST_SHIFT = 3'b010,
    ST_GAP = 3'b110
  } fps_state_t;

  // =====================================================================
  // command decode
  // =====================================================================
  function automatic logic [7:0] op_of(input fps_pkg::fps_cmd_t c);
    unique case (c)
      fps_pkg::CMD_SEC_READ: op_of = OP_SEC_READ;
      fps_pkg::CMD_SEC_WRITE: op_of = OP_SEC_WRITE;
      fps_pkg::CMD_PROT_SEL: op_of = OP_PROT_SEL;
      fps_pkg::CMD_LOCK: op_of = fps_pkg::OP_REGION_LOCK;
      fps_pkg::CMD_UNLOCK: op_of = fps_pkg::OP_REGION_UNLOCK;
      fps_pkg::CMD_LOCK_RD: op_of = fps_pkg::OP_LOCK_STATUS_READ;
      fps_pkg::CMD_CHIP_LOCK: op_of = fps_pkg::OP_CHIP_LOCK;
      fps_pkg::CMD_CHIP_UNLOCK: op_of = fps_pkg::OP_CHIP_UNLOCK;
      fps_pkg::CMD_SUSPEND: op_of = fps_pkg::OP_SUSPEND;
      fps_pkg::CMD_RESUME: op_of = fps_pkg::OP_RESUME;
      fps_pkg::CMD_NOP: op_of = OP_NOP;
      fps_pkg::CMD_RESET: op_of = fps_pkg::OP_RESET;
      default: op_of = OP_NOP;
    endcase
  endfunction

  // commands that need the write latch set frame in front
  function automatic logic needs_latch(input fps_pkg::fps_cmd_t c);
    needs_latch = (c == fps_pkg::CMD_SEC_WRITE) ||
                  (c == fps_pkg::CMD_PROT_SEL) ||
                  (c == fps_pkg::CMD_LOCK) || (c == fps_pkg::CMD_UNLOCK) ||
                  (c == fps_pkg::CMD_CHIP_LOCK) ||
                  (c == fps_pkg::CMD_CHIP_UNLOCK);
  endfunction

  function automatic logic has_addr(input fps_pkg::fps_cmd_t c);
    has_addr = (c == fps_pkg::CMD_LOCK) || (c == fps_pkg::CMD_UNLOCK) ||
               (c == fps_pkg::CMD_LOCK_RD);
  endfunction

  function automatic logic has_rx(input fps_pkg::fps_cmd_t c);
    has_rx = (c == fps_pkg::CMD_LOCK_RD) || (c == fps_pkg::CMD_SEC_READ);
  endfunction

  // =====================================================================
  // state
  // =====================================================================
  fps_state_t st_q, st_d;
  fps_pkg::fps_cmd_t code_q, code_d;
  fps_pkg::fps_rsp_t rsp_q, rsp_d;
  logic [23:0] addr_q, addr_d;
  logic [31:0] tx_q, tx_d;
  logic [7:0] rx_q, rx_d;
  logic [5:0] txb_q, txb_d;
  logic [5:0] rxb_q, rxb_d;
  logic [5:0] bit_q, bit_d;
  logic [7:0] div_q, div_d;
  logic [17:0] hold_q, hold_d;
  logic [17:0] resw_q, resw_d;
  logic pre_q, pre_d;
  logic susp_q, susp_d;
  logic ready_q, ready_d;
  logic busy_q, busy_d;
  logic cs_n_q, cs_n_d;
  logic sck_q, sck_d;
  logic mosi_q, mosi_d;
  logic miso_m_q;
  logic miso_s_q;

  // next values: sequencer, bit engine and holdoff timers
  always_comb begin
    st_d = st_q;
    code_d = code_q;
    addr_d = addr_q;
    tx_d = tx_q;
    rx_d = rx_q;
    txb_d = txb_q;
    rxb_d = rxb_q;
    bit_d = bit_q;
    div_d = div_q;
    pre_d = pre_q;
    susp_d = susp_q;
    busy_d = busy_q;
    cs_n_d = cs_n_q;
    sck_d = sck_q;
    mosi_d = mosi_q;
    rsp_d = rsp_q;
    rsp_d.valid = 1'b0;
    hold_d = (hold_q != 18'h00000) ? hold_q - 18'h00001 : hold_q;
    resw_d = (resw_q != 18'h00000) ? resw_q - 18'h00001 : resw_q;
    ready_d = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        ready_d = (hold_d == 18'h00000);
        if (req_valid && ready_q) begin
          code_d = req.code;
          addr_d = req.addr;
          // while suspended only reads, suspend, nop, resume and reset go out
          if (susp_q && needs_latch(req.code)) begin
            rsp_d.valid = 1'b1;
            rsp_d.err = 1'b1;
            rsp_d.data = 8'h00;
          end else begin
            ready_d = 1'b0;
            busy_d = 1'b1;
            st_d = ST_WAIT;
            // reset always goes as an arm frame plus a reset frame
            pre_d = needs_latch(req.code) ||
                    (req.code == fps_pkg::CMD_RESET);
          end
        end
      end
      ST_WAIT: begin
        // a suspend stalls here until the resume holdoff has run out
        if (!(code_q == fps_pkg::CMD_SUSPEND && resw_q != 18'h00000)) begin
          st_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (pre_q) begin
          tx_d = {(code_q == fps_pkg::CMD_RESET) ? fps_pkg::OP_RESET_ARM :
                  fps_pkg::OP_WRITE_LATCH_SET, 24'h000000};
          txb_d = fps_pkg::BITS_BYTE;
          rxb_d = fps_pkg::BITS_NONE;
        end else begin
          tx_d = {op_of(code_q), addr_q};
          txb_d = has_addr(code_q) ? fps_pkg::BITS_OP_ADDR :
                  fps_pkg::BITS_BYTE;
          rxb_d = has_rx(code_q) ? fps_pkg::BITS_BYTE :
                  fps_pkg::BITS_NONE;
        end
        mosi_d = tx_d[31];
        rx_d = 8'h00;
        cs_n_d = 1'b0;
        sck_d = 1'b0;
        bit_d = 6'h00;
        div_d = HALF_M1;
        st_d = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (div_q != 8'h00) begin
          div_d = div_q - 8'h01;
        end else begin
          div_d = HALF_M1;
          if (!sck_q) begin
            sck_d = 1'b1;
            if (bit_q >= txb_q) begin
              rx_d = {rx_q[6:0], miso_s_q};
            end
          end else begin
            sck_d = 1'b0;
            // frame length is whole bytes, so select rises on a boundary
            if (bit_q == txb_q + rxb_q - 6'h01) begin
              cs_n_d = 1'b1;
              div_d = GAP_M1;
              st_d = ST_GAP;
            end else begin
              bit_d = bit_q + 6'h01;
              tx_d = {tx_q[30:0], 1'b0};
              mosi_d = tx_q[30];
            end
          end
        end
      end
      ST_GAP: begin
        if (div_q != 8'h00) begin
          div_d = div_q - 8'h01;
        end else if (pre_q) begin
          pre_d = 1'b0;
          st_d = ST_LOAD;
        end else begin
          rsp_d.valid = 1'b1;
          rsp_d.err = 1'b0;
          rsp_d.data = rx_q;
          busy_d = 1'b0;
          st_d = ST_IDLE;
          unique case (code_q)
            fps_pkg::CMD_SUSPEND: begin
              susp_d = 1'b1;
              hold_d = SUSP_WAIT;
            end
            fps_pkg::CMD_RESUME: begin
              // no latch frame goes in front of a resume; completion of
              // the resumed write is left to the user to wait out
              susp_d = 1'b0;
              resw_d = RES_WAIT;
            end
            fps_pkg::CMD_RESET: begin
              // an aborted write needs the long recovery before traffic
              susp_d = 1'b0;
              hold_d = RST_WAIT;
              resw_d = 18'h00000;
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        st_d = ST_IDLE;
        cs_n_d = 1'b1;
        sck_d = 1'b0;
      end
    endcase
  end

  // register stage; miso passes two flops since it is an outside pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      code_q <= fps_pkg::CMD_NOP;
      addr_q <= 24'h000000;
      tx_q <= 32'h00000000;
      rx_q <= 8'h00;
      txb_q <= 6'h00;
      rxb_q <= 6'h00;
      bit_q <= 6'h00;
      div_q <= 8'h00;
      hold_q <= 18'h00000;
      resw_q <= 18'h00000;
      pre_q <= 1'b0;
      susp_q <= 1'b0;
      ready_q <= 1'b0;
      busy_q <= 1'b0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      rsp_q <= '0;
      miso_m_q <= 1'b0;
      miso_s_q <= 1'b0;
    end else begin
      st_q <= st_d;
      code_q <= code_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      txb_q <= txb_d;
      rxb_q <= rxb_d;
      bit_q <= bit_d;
      div_q <= div_d;
      hold_q <= hold_d;
      resw_q <= resw_d;
      pre_q <= pre_d;
      susp_q <= susp_d;
      ready_q <= ready_d;
      busy_q <= busy_d;
      cs_n_q <= cs_n_d;
      sck_q <= sck_d;
      mosi_q <= mosi_d;
      rsp_q <= rsp_d;
      miso_m_q <= flash_miso;
      miso_s_q <= miso_m_q;
    end
  end

  // =====================================================================
  // outputs straight from flops
  // =====================================================================
  assign req_ready = ready_q;
  assign rsp = rsp_q;
  assign busy = busy_q;
  assign flash_cs_n = cs_n_q;
  assign flash_sck = sck_q;
  assign flash_mosi = mosi_q;

endmodule

`default_nettype wire

// >>> test/fps_host_properties.sv
// checker: port timing properties of the flash protect host
`timescale 1ns/1ps
`default_nettype none
module fps_host_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req_valid,
  input wire fps_pkg::fps_req_t req,
  input wire logic req_ready,
  input wire fps_pkg::fps_rsp_t rsp,
  input wire logic busy,
  input wire logic flash_cs_n,
  input wire logic flash_sck,
  input wire logic flash_mosi,
  input wire logic flash_miso
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [5:0] bits_q, bits_d;
  logic sck_q;
  logic susp_q, susp_d;
  logic [12:0] hold_q, hold_d;
  // =====================================================================
  // helpers: sck rises per frame, holdoff left after a suspend
  always_comb begin
    bits_d = flash_cs_n ? 6'h00 : bits_q + {5'h00, flash_sck & ~sck_q};
    susp_d = susp_q;
    if (req_valid && req_ready) susp_d = req.code == fps_pkg::CMD_SUSPEND;
    hold_d = (hold_q != 13'h0000) ? hold_q - 13'h0001 : 13'h0000;
    if (rsp.valid && susp_q) hold_d = 13'(fps_pkg::SUSPEND_WAIT_CYC - 1);
  end
  // registers only; cleared with the design so a mid-run reset starts fresh
  always_ff @(posedge mclk) begin
    bits_q <= rst ? 6'h00 : bits_d;
    sck_q <= rst ? 1'b0 : flash_sck;
    susp_q <= rst ? 1'b0 : susp_d;
    hold_q <= rst ? 13'h0000 : hold_d;
  end
  sequence s_frame_end;
    $rose(flash_cs_n);
  endsequence
  sequence s_refusal;
    rsp.valid && rsp.err;
  endsequence
  // =====================================================================
  // properties
  a_reset_idle: assert property ($fell(rst) |-> flash_cs_n && !busy)
    else $error("lines not idle after reset");
  a_sck_idle: assert property (flash_cs_n |-> !flash_sck)
    else $error("sck high outside a frame");
  a_byte_bound: assert property (s_frame_end |-> bits_q[2:0] == 3'h0)
    else $error("frame ended off a byte boundary");
  a_mosi_hold: assert property (flash_sck |-> $stable(flash_mosi))
    else $error("mosi moved while sck high");
  a_rsp_pulse: assert property (rsp.valid |=> !rsp.valid)
    else $error("reply pulse longer than a cycle");
  a_refuse_quiet: assert property (s_refusal |-> $past(flash_cs_n, 2))
    else $error("refused request touched the pins");
  a_susp_hold: assert property (req_ready |-> hold_q == 13'h0000)
    else $error("ready before suspend holdoff ran out");
  a_frame_busy: assert property (!busy |-> flash_cs_n)
    else $error("frame open while idle");
endmodule
bind fps_host fps_host_properties fps_host_properties_inst (
  .mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .rsp(rsp), .busy(busy), .flash_cs_n(flash_cs_n),
  .flash_sck(flash_sck), .flash_mosi(flash_mosi), .flash_miso(flash_miso)
);
`default_nettype wire

// >>> test/fps_dev_model.sv
// partner: behavioural serial flash for protect, suspend and reset frames
`timescale 1ns/1ps
`default_nettype none
module fps_dev_model #(
  parameter logic [7:0] OP_SEC_READ = 8'hA1,
  parameter logic [7:0] OP_SEC_WRITE = 8'hA2,
  parameter logic [7:0] OP_PROT_SEL = 8'hA3,
  parameter logic [7:0] OP_IDLE = 8'h00
) (
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic prog_op,
  output logic miso
);
  logic [7:0] sec;
  logic [7:0] op;
  logic [7:0] tx;
  logic [31:0] sr;
  logic [15:0] lock;
  logic latch;
  logic arm;
  logic ok;
  int nb;
  // =====================================================================
  // power-on: mode bit clear, so no region starts locked
  initial begin
    sec = 8'h00;
    lock = {16{sec[7]}};
    latch = 1'b0;
    arm = 1'b0;
    miso = 1'b0;
    nb = 0;
  end
  always @(negedge cs_n) nb = 0;
  // shift in on rising sck, reply byte loaded once its part is in
  always @(posedge sck) begin
    if (!cs_n) begin
      sr = {sr[30:0], mosi};
      nb++;
      if (nb == 8) op = sr[7:0];
      if (nb == 8) tx = sec;
      if (nb == 32) tx = {7'h00, lock[sr[19:16]]};
    end
  end
  // reply moves on falling sck
  always @(negedge sck) begin
    miso = tx[7];
    tx = {tx[6:0], 1'b0};
  end
  // whole frames only; released line flips so a stale bit cannot pass
  always @(posedge cs_n) begin
    miso = ~miso;
    ok = sec[3:2] == 2'h0;
    ok = ok || op inside {OP_SEC_READ, 8'h3C, 8'h30, 8'h66, 8'h99};
    if (nb > 0 && nb % 8 == 0 && ok) begin
      case (op)
        8'h06: latch = 1'b1;
        OP_SEC_WRITE: sec[1] = sec[1] | latch;
        OP_PROT_SEL: sec[7] = sec[7] | latch;
        8'h36: if (latch && sec[7]) lock[sr[19:16]] = 1'b1;
        8'h39: if (latch && sec[7]) lock[sr[19:16]] = 1'b0;
        8'h7E: if (latch && sec[7]) lock = 16'hFFFF;
        8'h98: if (latch && sec[7]) lock = 16'h0000;
        8'hB0: sec[prog_op ? 2 : 3] = 1'b1;
        8'h30: sec[3:2] = 2'h0;
        8'h99: if (arm) sec[6:2] = 5'h00;
        OP_IDLE: ;
        default: ;
      endcase
      if (op inside {OP_SEC_WRITE, OP_PROT_SEL, 8'h36, 8'h39, 8'h7E, 8'h98,
          8'hB0, 8'h99}) latch = 1'b0;
      arm = op == 8'h66;
    end
  end
endmodule
`default_nettype wire

// >>> test/tb.sv
// testbench: host controller against the behavioural flash
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int GAP = 50;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic prog_op = 1'b0;
  fps_pkg::fps_req_t req = '0;
  fps_pkg::fps_rsp_t rsp;
  fps_pkg::fps_rsp_t got;
  logic req_ready, busy, flash_cs_n, flash_sck, flash_mosi, flash_miso;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last_res = -100000;
  // rows: code, region, err, reply byte
  logic [19:0] rows [27] = '{
    20'h0_0_0_00, 20'h6_0_0_00, 20'h5_0_0_00,
    20'h2_0_0_00, 20'h0_0_0_80, 20'h6_0_0_00,
    20'h5_5_0_01, 20'h4_5_0_00, 20'h5_5_0_00,
    20'h5_6_0_01, 20'h7_0_0_00, 20'h3_2_0_00,
    20'h5_2_0_01, 20'h5_3_0_00, 20'h1_0_0_00,
    20'h0_0_0_82, 20'h8_0_0_00, 20'h0_0_0_8A,
    20'h6_0_1_00, 20'h5_3_0_00, 20'h9_0_0_00,
    20'h8_0_0_00, 20'h0_0_0_86, 20'hB_0_0_00,
    20'h0_0_0_82, 20'hA_0_0_00, 20'h5_2_0_01
  };
  fps_host #(.RESUME_GAP_CYC(GAP), .RECOVER_CYC(20)) fps_host_inst (
    .mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp(rsp), .busy(busy), .flash_cs_n(flash_cs_n),
    .flash_sck(flash_sck), .flash_mosi(flash_mosi), .flash_miso(flash_miso)
  );
  fps_dev_model fps_dev_model_inst (
    .cs_n(flash_cs_n), .sck(flash_sck), .mosi(flash_mosi),
    .prog_op(prog_op), .miso(flash_miso)
  );
  always #2.5 mclk = ~mclk;
  // =====================================================================
  // run limit: two suspend holdoffs dominate, well under this
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp_bit(string what, logic exp, logic seen);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic cmp_byte(string what, logic [7:0] exp, logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one request: wait ready, hold valid over the taking edge, await reply
  task automatic run(fps_pkg::fps_cmd_t c, logic [23:0] a);
    int n;
    n = 0;
    @(negedge mclk);
    while (req_ready !== 1'b1 && n < 8000) begin
      @(negedge mclk);
      n++;
    end
    req = '{c, a};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    while (rsp.valid !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    got = rsp;
    // a stalled suspend ends no sooner than the gap plus one opcode frame
    if (c == fps_pkg::CMD_SUSPEND)
      cmp_bit("resume gap", 1'b1, cyc - last_res >= GAP + 75);
    if (c == fps_pkg::CMD_RESUME) last_res = cyc;
  endtask
  // =====================================================================
  // main sequence: table rows, then a reset cut into a frame
  initial begin
    repeat (8) @(negedge mclk);
    cmp_bit("cs_n in reset", 1'b1, flash_cs_n);
    cmp_bit("ready in reset", 1'b0, req_ready);
    rst = 1'b0;
    for (int i = 0; i < 27; i++) begin
      prog_op = i >= 21;
      run(fps_pkg::fps_cmd_t'(rows[i][19:16]), {4'h0, rows[i][15:12], 16'h0000});
      cmp_bit("err", rows[i][8], got.err);
      cmp_byte("data", rows[i][7:0], got.data);
      $display("row %0d done", i);
    end
    @(negedge mclk);
    req = '{fps_pkg::CMD_CHIP_LOCK, 24'h000000};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    repeat (20) @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    cmp_bit("cs_n after cut", 1'b1, flash_cs_n);
    cmp_bit("busy after cut", 1'b0, busy);
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    run(fps_pkg::CMD_LOCK_RD, 24'h030000);
    cmp_byte("cut lock", 8'h00, got.data);
    $display("reset cut test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
